// file: rtl/lmpd_pkg.sv
// Constants, register map and field layout of the linear motor pole detection block.
// Assumes a single 40 MHz clock and a plain single-cycle register port.
package lmpd_pkg;
  // ==========================================================================
  // Widths
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int ANG_W  = 9;
  localparam int CNT_W  = 16;
  localparam int PRM_W  = 15;
  localparam int IRQ_W  = 4;

  // ==========================================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PHASE    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_T_TIME   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_T_LEVEL  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_ZERO     = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STOP_PC  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STOP_T   = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_LIMIT    = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ST   = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h28;

  // ==========================================================================
  // Fields and encodings
  localparam int CTRL_METH_LSB = 0;
  localparam int CTRL_REV_LSB  = 2;
  localparam int REV_SCALE_BIT = 0;
  localparam int REV_SENSE_BIT = 1;
  localparam logic [1:0] METH_NONE   = 2'h0;
  localparam logic [1:0] METH_SENSOR = 2'h1;
  localparam logic [1:0] METH_EST    = 2'h2;
  localparam logic [1:0] METH_RECOV  = 2'h3;
  localparam int IRQ_SET_ERR = 0;
  localparam int IRQ_TIMEOUT = 1;
  localparam int IRQ_DONE    = 2;
  localparam int IRQ_ZERO    = 3;
  localparam int ST_VALID_BIT = 0;
  localparam int ST_BUSY_BIT  = 1;
  localparam int ST_COMM_BIT  = 2;
  localparam int ST_SETE_BIT  = 3;
  localparam int ST_TOUT_BIT  = 4;
  localparam int ST_ARMED_BIT = 5;
  localparam int ST_ANG_LSB   = 16;

  // ==========================================================================
  // Angles and limits
  localparam logic [ANG_W-1:0] ANG_FULL    = 9'h168;
  localparam logic [ANG_W-1:0] ANG_SECTOR  = 9'h03C;
  localparam logic [ANG_W-1:0] STEP_ANGLE  = 9'h05A;
  localparam logic [ANG_W-1:0] MAX_THRUST  = 9'h12C;
  localparam logic [7:0]       T_TIME_MAX  = 8'hC8;
  localparam int               EST_STEPS   = 4;

  // ==========================================================================
  // Timing
  localparam int CLK_FREQ_HZ = 40_000_000;
  localparam int TICK_MS     = 1;
  localparam int TICK_CYC    = CLK_FREQ_HZ / 1000 * TICK_MS;
  localparam int SAMPLE_MS   = 2;
  localparam int EXTRA_MS    = 4;
  localparam logic [CNT_W-1:0] SAMPLE_MS_W = 16'(SAMPLE_MS);
  localparam logic [CNT_W-1:0] EXTRA_MS_W  = 16'(EXTRA_MS);

  // ==========================================================================
  // Reset values
  localparam logic [1:0]       RST_METHOD = 2'h0;
  localparam logic [1:0]       RST_REV    = 2'h0;
  localparam logic [IRQ_W-1:0] RST_MASK   = 4'h0;
endpackage : lmpd_pkg

// file: rtl/lmpd_hall_decode.sv
// Decoder from three commutation sensor levels to a 60 degree sector angle.
// Assumes inputs are already synchronised to the block clock.
`timescale 1ns/1ps
module lmpd_hall_decode
  import lmpd_pkg::*;
(
  // Sensor levels and line swap
  input  wire logic             i_a,
  input  wire logic             i_b,
  input  wire logic             i_c,
  input  wire logic             i_swap,
  // Decoded sector
  output logic                  o_valid,
  output logic [ANG_W-1:0]      o_angle
);
  logic [2:0] code;

  // ==========================================================================
  // Decode
  // Swapping the second and third lines corrects a crossed sensor harness.
  assign code = i_swap ? {i_a, i_c, i_b} : {i_a, i_b, i_c};

  always_comb begin
    o_valid = 1'b1;
    o_angle = '0;
    case (code)
      3'h4: o_angle = '0;
      3'h6: o_angle = ANG_SECTOR;
      3'h2: o_angle = 9'(ANG_SECTOR * 2);
      3'h3: o_angle = 9'(ANG_SECTOR * 3);
      3'h1: o_angle = 9'(ANG_SECTOR * 4);
      3'h5: o_angle = 9'(ANG_SECTOR * 5);
      default: o_valid = 1'b0;
    endcase
  end
endmodule : lmpd_hall_decode

// file: rtl/lmpd_core.sv
// Pole position detection for a linear servo motor: sensor decoding, thrust-pulse estimation,
// register port and interrupt. Assumes scale count and servo command come from same-clock logic.
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
module lmpd_core
  import lmpd_pkg::*;
#(
  parameter int               TICK_MS_CYC = TICK_CYC,
  parameter logic [ANG_W-1:0] THRUST_MAX  = MAX_THRUST
) (
  // Clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst,
  // Register port
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wr_data,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic [DATA_W-1:0]      o_rd_data,
  output logic                   o_irq,
  // Host commands
  input  wire logic              i_servo_on,
  input  wire logic              i_soft_reset,
  // Motor side
  input  wire logic              i_commutation_sense_a,
  input  wire logic              i_commutation_sense_b,
  input  wire logic              i_commutation_sense_c,
  input  wire logic [CNT_W-1:0]  i_scale_count,
  output logic [ANG_W-1:0]       o_thrust_cmd,
  output logic [ANG_W-1:0]       o_thrust_angle,
  output logic                   o_scale_count_rev,
  // Pole state
  output logic                   o_pole_valid,
  output logic [ANG_W-1:0]       o_pole_angle,
  output logic                   o_commutation_en,
  output logic                   o_est_busy,
  output logic                   o_motor_setting_error,
  output logic                   o_estimation_timeout_error
);
  typedef enum logic [1:0] {ST_IDLE, ST_THRUST, ST_SETTLE} lmpd_state_t;

  typedef struct packed {
    logic [2:0]              sync1;
    logic [2:0]              sync2;
    logic [1:0]              method;
    logic [1:0]              rev;
    logic [ANG_W-1:0]        phase;
    logic [7:0]              t_time;
    logic [ANG_W-1:0]        t_level;
    logic [PRM_W-1:0]        zero;
    logic [PRM_W-1:0]        stop_pc;
    logic [PRM_W-1:0]        stop_t;
    logic [PRM_W-1:0]        limit;
    logic [7:0]              l_time;
    logic [ANG_W-1:0]        l_level;
    logic [PRM_W-1:0]        l_zero;
    logic [PRM_W-1:0]        l_stop_pc;
    logic [PRM_W-1:0]        l_stop_t;
    logic [PRM_W-1:0]        l_limit;
    logic [IRQ_W-1:0]        irq_st;
    logic [IRQ_W-1:0]        irq_mask;
    logic [DATA_W-1:0]       rd_data;
    logic                    irq;
    lmpd_state_t             st;
    logic                    armed;
    logic                    busy;
    logic                    est_valid;
    logic [ANG_W-1:0]        est_angle;
    logic [16:0]             tick_cnt;
    logic                    ms_tick;
    logic                    ms_par;
    logic [CNT_W-1:0]        tmr_ms;
    logic [CNT_W-1:0]        wait_ms;
    logic [CNT_W-1:0]        stop_acc;
    logic [CNT_W-1:0]        ref_cnt;
    logic [1:0]              step;
    logic signed [CNT_W-1:0] best;
    logic [ANG_W-1:0]        best_angle;
    logic [ANG_W-1:0]        thrust;
    logic [ANG_W-1:0]        thrust_angle;
    logic                    pole_valid;
    logic [ANG_W-1:0]        pole_angle;
    logic                    comm_en;
    logic                    set_err;
    logic                    to_err;
  } lmpd_reg_t;

  lmpd_reg_t        r;
  lmpd_reg_t        n;
  logic             dec_valid;
  logic [ANG_W-1:0] dec_angle;
  logic             swap;

  // ==========================================================================
  // Sensor decode
  assign swap = (r.method == METH_SENSOR) && r.rev[REV_SENSE_BIT];

  lmpd_hall_decode u_dec (
    .i_a     (r.sync2[2]),
    .i_b     (r.sync2[1]),
    .i_c     (r.sync2[0]),
    .i_swap  (swap),
    .o_valid (dec_valid),
    .o_angle (dec_angle)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    logic [IRQ_W-1:0]        ev;
    logic signed [CNT_W-1:0] delta;
    logic [CNT_W-1:0]        mag;
    logic [ANG_W:0]          sum;
    logic                    thr_end;
    ev      = '0;
    delta   = '0;
    mag     = '0;
    sum     = '0;
    thr_end = 1'b0;
    n       = r;
    n.sync1 = {i_commutation_sense_a, i_commutation_sense_b, i_commutation_sense_c};
    n.sync2 = r.sync1;

    // Register writes still land during estimation; the latched copies steer it.
    if (i_wr) begin
      case (i_addr)
        OFS_CTRL: begin
          n.method = i_wr_data[CTRL_METH_LSB +: 2];
          n.rev    = i_wr_data[CTRL_REV_LSB +: 2];
        end
        OFS_PHASE: n.phase = (i_wr_data[ANG_W-1:0] > ANG_FULL) ? ANG_FULL
                                                               : i_wr_data[ANG_W-1:0];
        OFS_T_TIME: n.t_time = (i_wr_data[7:0] > T_TIME_MAX) ? T_TIME_MAX : i_wr_data[7:0];
        OFS_T_LEVEL:  n.t_level  = i_wr_data[ANG_W-1:0];
        OFS_ZERO:     n.zero     = i_wr_data[PRM_W-1:0];
        OFS_STOP_PC:  n.stop_pc  = i_wr_data[PRM_W-1:0];
        OFS_STOP_T:   n.stop_t   = i_wr_data[PRM_W-1:0];
        OFS_LIMIT:    n.limit    = i_wr_data[PRM_W-1:0];
        OFS_IRQ_MASK: n.irq_mask = i_wr_data[IRQ_W-1:0];
        default: ;
      endcase
    end

    n.rd_data = '0;
    if (i_rd) begin
      case (i_addr)
        OFS_CTRL:     n.rd_data = {28'h0000000, r.rev, r.method};
        OFS_PHASE:    n.rd_data = {23'h000000, r.phase};
        OFS_T_TIME:   n.rd_data = {24'h000000, r.t_time};
        OFS_T_LEVEL:  n.rd_data = {23'h000000, r.t_level};
        OFS_ZERO:     n.rd_data = {17'h00000, r.zero};
        OFS_STOP_PC:  n.rd_data = {17'h00000, r.stop_pc};
        OFS_STOP_T:   n.rd_data = {17'h00000, r.stop_t};
        OFS_LIMIT:    n.rd_data = {17'h00000, r.limit};
        OFS_IRQ_ST:   n.rd_data = {28'h0000000, r.irq_st};
        OFS_IRQ_MASK: n.rd_data = {28'h0000000, r.irq_mask};
        OFS_STATUS: begin
          n.rd_data[ST_VALID_BIT]              = r.pole_valid;
          n.rd_data[ST_BUSY_BIT]               = r.busy;
          n.rd_data[ST_COMM_BIT]               = r.comm_en;
          n.rd_data[ST_SETE_BIT]               = r.set_err;
          n.rd_data[ST_TOUT_BIT]               = r.to_err;
          n.rd_data[ST_ARMED_BIT]              = r.armed;
          n.rd_data[ST_ANG_LSB +: ANG_W]       = r.pole_angle;
        end
        default: ;
      endcase
    end

    // Millisecond tick from the block clock.
    n.ms_tick = 1'b0;
    if (r.tick_cnt == 17'(TICK_MS_CYC - 1)) begin
      n.tick_cnt = '0;
      n.ms_tick  = 1'b1;
    end else begin
      n.tick_cnt = r.tick_cnt + 17'h00001;
    end

    // Movement since the reference point, in the scale direction chosen.
    delta = signed'(i_scale_count - r.ref_cnt);
    if (r.rev[REV_SCALE_BIT]) begin
      delta = -delta;
    end
    mag = delta[CNT_W-1] ? CNT_W'(-delta) : CNT_W'(delta);

    n.set_err = (r.method == METH_NONE);
    ev[IRQ_SET_ERR] = n.set_err && !r.set_err;

    unique case (r.st)
      ST_IDLE: begin
        if (r.method == METH_EST && r.armed && i_servo_on && !r.to_err) begin
          n.armed     = 1'b0;
          n.busy      = 1'b1;
          n.l_time    = r.t_time;
          n.l_level   = r.t_level;
          n.l_zero    = r.zero;
          n.l_stop_pc = r.stop_pc;
          n.l_stop_t  = r.stop_t;
          n.l_limit   = r.limit;
          n.step      = '0;
          n.best      = 16'sh8000;
          n.tmr_ms    = '0;
          n.ref_cnt   = i_scale_count;
          n.thrust    = (r.t_level > THRUST_MAX) ? THRUST_MAX : r.t_level;
          n.thrust_angle = '0;
          n.st        = ST_THRUST;
        end
      end
      ST_THRUST: begin
        if (r.ms_tick) begin
          n.tmr_ms = r.tmr_ms + 16'h0001;
        end
        thr_end = (mag > {1'b0, r.l_zero}) ||
                  (r.tmr_ms >= 16'(16'(r.l_time) + EXTRA_MS_W));
        if (thr_end) begin
          n.thrust = '0;
          ev[IRQ_ZERO] = (mag < {1'b0, r.l_zero});
          if (delta > r.best) begin
            n.best       = delta;
            n.best_angle = r.thrust_angle;
          end
          n.ref_cnt  = i_scale_count;
          n.wait_ms  = '0;
          n.stop_acc = '0;
          n.ms_par   = 1'b0;
          n.st       = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (r.ms_tick) begin
          n.wait_ms = r.wait_ms + 16'h0001;
          n.ms_par  = !r.ms_par;
          if (r.ms_par) begin
            n.ref_cnt  = i_scale_count;
            n.stop_acc = (mag <= {1'b0, r.l_stop_pc}) ?
                         16'(r.stop_acc + SAMPLE_MS_W) : '0;
          end
        end
        if (r.stop_acc >= {1'b0, r.l_stop_t}) begin
          if (r.step == 2'(EST_STEPS - 1)) begin
            n.est_valid = 1'b1;
            n.est_angle = r.best_angle;
            n.busy      = 1'b0;
            ev[IRQ_DONE] = 1'b1;
            n.st        = ST_IDLE;
          end else begin
            n.step         = r.step + 2'h1;
            n.thrust_angle = r.thrust_angle + STEP_ANGLE;
            n.thrust       = (r.l_level > THRUST_MAX) ? THRUST_MAX : r.l_level;
            n.tmr_ms       = '0;
            n.ref_cnt      = i_scale_count;
            n.st           = ST_THRUST;
          end
        end else if (r.wait_ms >= {1'b0, r.l_limit}) begin
          n.to_err = 1'b1;
          ev[IRQ_TIMEOUT] = 1'b1;
          n.busy  = 1'b0;
          n.st    = ST_IDLE;
        end
      end
    endcase

    // Losing servo-on mid estimation aborts and re-arms the next servo-on.
    if (r.st != ST_IDLE && !i_servo_on) begin
      n.thrust = '0;
      n.busy   = 1'b0;
      n.armed  = 1'b1;
      n.st     = ST_IDLE;
    end
    if (i_soft_reset) begin
      n.armed     = 1'b1;
      n.est_valid = 1'b0;
      n.to_err    = 1'b0;
      n.busy      = 1'b0;
      n.thrust    = '0;
      n.st        = ST_IDLE;
    end

    // Pole position output.
    sum = {1'b0, dec_angle} + {1'b0, r.phase};
    if (sum >= {1'b0, ANG_FULL}) begin
      sum = sum - {1'b0, ANG_FULL};
    end
    n.pole_valid = 1'b0;
    n.pole_angle = '0;
    if (r.method == METH_SENSOR) begin
      n.pole_valid = dec_valid;
      n.pole_angle = sum[ANG_W-1:0];
    end else if (r.method == METH_EST) begin
      n.pole_valid = r.est_valid;
      n.pole_angle = r.est_angle;
    end
    n.comm_en = n.pole_valid;

    // Set wins over the read that clears.
    n.irq_st = ((i_rd && i_addr == OFS_IRQ_ST) ? '0 : r.irq_st) | ev;
    n.irq    = |(n.irq_st & n.irq_mask);
  end

  // ==========================================================================
  // State register
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      r          <= '0;
      r.armed    <= 1'b1;
      r.method   <= RST_METHOD;
      r.rev      <= RST_REV;
      r.irq_mask <= RST_MASK;
    end else begin
      r <= n;
    end
  end

  assign o_rd_data                  = r.rd_data;
  assign o_irq                      = r.irq;
  assign o_thrust_cmd               = r.thrust;
  assign o_thrust_angle             = r.thrust_angle;
  assign o_scale_count_rev          = r.rev[REV_SCALE_BIT];
  assign o_pole_valid               = r.pole_valid;
  assign o_pole_angle               = r.pole_angle;
  assign o_commutation_en           = r.comm_en;
  assign o_est_busy                 = r.busy;
  assign o_motor_setting_error      = r.set_err;
  assign o_estimation_timeout_error = r.to_err;

  // ==========================================================================
  // Checks
  setting_error_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (r.method == METH_NONE) |=> o_motor_setting_error)
    else $error("method zero did not raise setting error");
  comm_gate_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !o_pole_valid |-> !o_commutation_en)
    else $error("commutation enabled without valid pole");
  phase_wrap_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_pole_valid |-> (o_pole_angle < ANG_FULL))
    else $error("pole angle out of range");
  est_latch_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (r.busy && $past(r.busy)) |-> ($stable(r.l_zero) && $stable(r.l_time)))
    else $error("latched settings changed during estimation");
  timeout_idle_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(o_estimation_timeout_error) |-> (!o_est_busy && o_thrust_cmd == '0))
    else $error("timeout left estimation running");
  thrust_est_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (o_thrust_cmd != '0) |-> (o_est_busy && r.st == ST_THRUST))
    else $error("thrust outside estimation");
  thrust_clamp_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_thrust_cmd <= THRUST_MAX)
    else $error("thrust above motor maximum");
  start_once_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(o_est_busy) |-> (!r.armed && $past(i_servo_on) && $past(r.method) == METH_EST))
    else $error("estimation started without first servo-on");
  swap_gate_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (r.method != METH_SENSOR) |-> !swap)
    else $error("sensor swap active outside sensor method");
endmodule : lmpd_core

// file: bench/lmpd_motor_model.sv
// Behavioural linear motor: commutation sensor levels from a pole sector, scale count from thrust.
// Assumes the block clock; the bench picks sector, sensor wiring and a creep fault.
`timescale 1ns/1ps
module lmpd_motor_model
  import lmpd_pkg::*;
(
  // Clock
  input  wire logic             i_ref_clk,
  // Bench controls
  input  wire logic [2:0]       i_sector,
  input  wire logic             i_wire_swap,
  input  wire logic             i_creep,
  input  wire logic [ANG_W-1:0] i_pole,
  // Block side
  input  wire logic [ANG_W-1:0] i_thrust_cmd,
  input  wire logic [ANG_W-1:0] i_thrust_angle,
  output logic                  o_a,
  output logic                  o_b,
  output logic                  o_c,
  output logic [CNT_W-1:0]      o_count
);
  // ====================================================================
  // Sensors
  localparam logic [17:0] LUT = {3'h5, 3'h1, 3'h3, 3'h2, 3'h6, 3'h4};
  logic [2:0] code;
  assign code = LUT[i_sector*3 +: 3];
  // Swapped wiring is the fault the reversal setting must undo.
  assign {o_a, o_b, o_c} = i_wire_swap ? {code[2], code[0], code[1]} : code;
  // ====================================================================
  // Slide
  // Only a thrust aligned with the pole moves; creep never settles, so it forces a timeout.
  initial o_count = '0;
  always @(posedge i_ref_clk) begin
    if (i_creep || (i_thrust_cmd != '0 && i_thrust_angle == i_pole)) begin
      o_count <= o_count + 16'h1;
    end
  end
endmodule : lmpd_motor_model

// file: bench/tb_top.sv
// Self-checking bench for the pole detection core beside a behavioural motor.
// Assumes the core register map of the shared package, with the millisecond tick cut to 4 cycles.
`timescale 1ns/1ps
module tb_top;
  import lmpd_pkg::*;
  // ====================================================================
  // Signals
  logic              i_ref_clk, i_rst, i_wr, i_rd, i_servo_on, i_soft_reset, sa, sb, sc;
  logic              o_irq, o_scale_count_rev, o_pole_valid, o_commutation_en, o_est_busy;
  logic              o_motor_setting_error, o_estimation_timeout_error, swap, creep, rd_pend;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wr_data, o_rd_data, q_exp[$], q_msk[$];
  logic [ANG_W-1:0]  o_thrust_cmd, o_thrust_angle, o_pole_angle, lvl;
  logic [CNT_W-1:0]  cnt;
  logic [2:0]        sector;
  int                err_count, num_checks, dur, ph, durs[4];

  initial begin
    i_ref_clk = 0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end

  lmpd_core #(.TICK_MS_CYC(4)) dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .o_irq(o_irq),
    .i_servo_on(i_servo_on), .i_soft_reset(i_soft_reset), .i_commutation_sense_a(sa),
    .i_commutation_sense_b(sb), .i_commutation_sense_c(sc), .i_scale_count(cnt),
    .o_thrust_cmd(o_thrust_cmd), .o_thrust_angle(o_thrust_angle),
    .o_scale_count_rev(o_scale_count_rev), .o_pole_valid(o_pole_valid),
    .o_pole_angle(o_pole_angle), .o_commutation_en(o_commutation_en), .o_est_busy(o_est_busy),
    .o_motor_setting_error(o_motor_setting_error),
    .o_estimation_timeout_error(o_estimation_timeout_error));

  lmpd_motor_model motor (.i_ref_clk(i_ref_clk), .i_sector(sector), .i_wire_swap(swap),
    .i_creep(creep), .i_pole(9'h0B4), .i_thrust_cmd(o_thrust_cmd),
    .i_thrust_angle(o_thrust_angle), .o_a(sa), .o_b(sb), .o_c(sc), .o_count(cnt));

  // ====================================================================
  // Tasks
  task automatic results();
    $display("Checks %0d, errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // Every call drives both strobes, so no signal is assigned twice in one time step.
  task automatic bus(input logic w, input logic r, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_ref_clk);
    #1;
  endtask : bus

  task automatic idle(input int n);
    repeat (n) bus(0, 0, '0, '0);
  endtask : idle

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
                    input logic [DATA_W-1:0] m);
    q_exp.push_back(e);
    q_msk.push_back(m);
    bus(0, 1, a, '0);
  endtask : rd

  // Selector 0 waits for busy, 1 for idle, 2 for the timeout error.
  task automatic await(input int sel, input int lim);
    int n;
    n = 0;
    while ((sel == 0 ? o_est_busy : sel == 1 ? !o_est_busy : o_estimation_timeout_error)
           !== 1'b1) begin
      if (n == lim) begin
        err_count++;
        $display("Error at %0t: wait %0d ran out, got %0h expected %0h", $time, sel, 0, 1);
        results();
      end
      n++;
      idle(1);
    end
  endtask : await

  task automatic soft_reset();
    i_soft_reset <= 1;
    idle(1);
    i_soft_reset <= 0;
    idle(1);
  endtask : soft_reset

  // ====================================================================
  // Monitors
  always @(posedge i_ref_clk) rd_pend <= i_rd;
  always @(negedge i_ref_clk) begin
    if (rd_pend === 1'b1) begin
      chk(o_rd_data & q_msk.pop_front(), q_exp.pop_front());
    end
  end
  always @(posedge i_ref_clk) begin
    if (o_thrust_cmd != '0) begin
      dur <= dur + 1;
      lvl <= o_thrust_cmd;
    end else if (dur != 0) begin
      durs[o_thrust_angle / STEP_ANGLE] <= dur;
      dur <= 0;
    end
  end

  // ====================================================================
  // Sequence
  initial begin
    {i_wr, i_rd, i_addr, i_wr_data, i_servo_on, i_soft_reset} = '0;
    i_rst = 1;
    {sector, swap, creep, rd_pend, lvl} = '0;
    {dur, err_count, num_checks} = '0;
    void'($urandom(32'h3ECE));
    repeat (12) @(posedge i_ref_clk);
    i_rst <= 0;
    idle(2);
    chk(o_pole_valid, 0);
    chk(o_commutation_en, 0);
    chk(o_motor_setting_error, 1);
    bus(1, 0, OFS_IRQ_MASK, 32'hF);
    idle(2);
    chk(o_irq, 1);
    rd(OFS_IRQ_ST, 32'h1, 32'h1);
    rd(8'h40, 32'h0, 32'hFFFFFFFF);
    idle(2);
    chk(o_irq, 0);
    bus(1, 0, OFS_T_TIME, 32'h2);
    bus(1, 0, OFS_T_LEVEL, 32'h15E);
    bus(1, 0, OFS_ZERO, 32'h5);
    bus(1, 0, OFS_STOP_PC, 32'h1);
    bus(1, 0, OFS_STOP_T, 32'h2);
    bus(1, 0, OFS_LIMIT, 32'h32);
    bus(1, 0, OFS_CTRL, {30'h0, METH_EST});
    i_servo_on <= 1;
    await(0, 50);
    bus(1, 0, OFS_T_LEVEL, 32'hA);
    await(1, 4000);
    idle(1);
    chk(o_pole_valid, 1);
    chk(o_pole_angle, 9'h0B4);
    chk(o_commutation_en, 1);
    rd(OFS_STATUS, 32'h00B40005, 32'h01FF003F);
    chk(lvl, MAX_THRUST);
    chk(durs[2] < 12, 1);
    chk(durs[0] >= 20 && durs[0] <= 28, 1);
    rd(OFS_IRQ_ST, 32'hC, 32'hC);
    i_servo_on <= 0;
    idle(4);
    i_servo_on <= 1;
    idle(40);
    chk(o_est_busy, 0);
    chk(o_pole_valid, 1);
    soft_reset();
    chk(o_pole_valid, 0);
    await(0, 50);
    await(1, 4000);
    creep <= 1;
    soft_reset();
    await(2, 4000);
    chk(o_est_busy, 0);
    rd(OFS_IRQ_ST, 32'h2, 32'h2);
    creep <= 0;
    i_servo_on <= 0;
    soft_reset();
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 6; k++) begin
        ph = $urandom_range(360);
        sector <= k[2:0];
        swap <= s[0];
        bus(1, 0, OFS_PHASE, ph);
        bus(1, 0, OFS_CTRL, {28'h0, s[0], k[0], METH_SENSOR});
        idle(6);
        chk(o_pole_valid, 1);
        chk(o_pole_angle, (60 * k + ph) % 360);
        chk(o_scale_count_rev, k[0]);
      end
    end
    swap <= 0;
    sector <= 3'h1;
    bus(1, 0, OFS_CTRL, 32'h1);
    bus(1, 0, OFS_PHASE, 32'h190);
    rd(OFS_PHASE, 32'h168, 32'h1FF);
    idle(6);
    chk(o_pole_angle, 9'h03C);
    bus(1, 0, OFS_CTRL, 32'h9);
    idle(6);
    chk(o_pole_angle, 9'h12C);
    for (int m = 3; m >= 0; m--) begin
      bus(1, 0, OFS_CTRL, m);
      idle(3);
      chk(o_motor_setting_error, m == 0);
    end
    bus(1, 0, OFS_CTRL, 32'h1);
    rd(OFS_IRQ_ST, 32'h1, 32'h1);
    bus(1, 0, OFS_IRQ_MASK, 32'h0);
    bus(1, 0, OFS_CTRL, 32'h0);
    idle(3);
    chk(o_irq, 0);
    bus(1, 0, OFS_IRQ_MASK, 32'h1);
    idle(3);
    chk(o_irq, 1);
    results();
  end
endmodule : tb_top
